// [hdl/ptr_unit.v]
`timescale 1ns/10ps
`default_nettype none

// Pointer with load and post increment or decrement that wraps in its width.
module ptr_unit #(
   parameter W = 8
) (
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         load,
   input  wire [W-1:0] load_val,
   input  wire         step_up,
   input  wire         step_down,
   output reg  [W-1:0] ptr_q
);

   // Natural binary wrap keeps the pointer inside its memory.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ptr_q <= {W{1'b0}};
      end else if (load) begin
         ptr_q <= load_val;
      end else if (step_up) begin
         ptr_q <= ptr_q + {{(W-1){1'b0}}, 1'b1};
      end else if (step_down) begin
         ptr_q <= ptr_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

`default_nettype wire

// [hdl/variable_memory_store.v]
// What this block does
// - Byte arithmetic wraps modulo 256 silently.
// - Word n is byte 2n+1 high, 2n low.
// - Bit variables map onto bytes 0 and up.
// - Named file: 56 bytes, 28 words, 32 bits.
// - General file holds 256 directly reachable bytes.
// - Indirect operand uses byte pointer address.
// - Post-increment advances byte pointer after access.
// - Scratchpad holds 1024 directly addressed bytes.
// - Scratchpad indirect via its pointer, post-increment.
// - Both pointers also offer post-decrement.
// - Eight system words and one flags byte.
// - Unused system storage behaves as plain storage.
// - Flags 0-2 external, 3 any, 4 comparator.
// - Flags 5 serial, 6 slave write, 7 overflow.
// - Storage bytes reachable only by direct or byte pointer access.
// - Reset clears all variable memory.
// - Port reads valid only at bits 1-4.
// - Direction bits exist at 1, 2, 4 only.
// - Direction bit selects input or output.
`timescale 1ns/10ps
`default_nettype none
`include "vms_defs.vh"

module variable_memory_store (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [7:0]  sys_hw_we,
   input  wire [15:0] sys_hw_data,
   input  wire [2:0]  ext_int_evt,
   input  wire        comp_change_evt,
   input  wire        serial_rx_evt,
   input  wire        slave_write_evt,
   input  wire        timer_ovf_evt,
   input  wire [7:0]  pin_in,
   output reg  [7:0]  pin_out,
   output reg  [7:0]  pin_oe_n
);

   // Variable stores.
   reg  [7:0]  gp_mem [0:`VMS_GP_DEPTH-1];
   reg  [7:0]  sp_mem [0:`VMS_SP_DEPTH-1];
   reg  [15:0] sys_q  [0:`VMS_SYS_WORDS-1];

   // Selection and control registers.
   reg  [7:0]  gp_addr_q;
   reg  [4:0]  word_sel_q;
   reg  [4:0]  bit_sel_q;
   reg  [9:0]  sp_addr_q;
   reg  [2:0]  sys_sel_q;
   reg  [7:0]  flags_q;
   reg  [7:0]  flags_d;
   reg  [7:0]  port_out_q;
   reg  [7:0]  dir_q;
   reg  [9:0]  clr_cnt_q;
   reg         clearing_q;
   reg  [31:0] rd_d;
   reg         err_d;
   reg  [7:0]  bit_new;
   integer     i;

   wire [7:0]  bptr;
   wire [9:0]  ptr;
   wire        acc;
   wire        done;
   wire        wr_done;
   wire        word_ok;
   wire [7:0]  word_lo_a;
   wire [7:0]  word_hi_a;
   wire [7:0]  bit_byte_a;
   wire [7:0]  bit_byte;
   wire [7:0]  op_addr;
   wire        op_ok;
   wire [7:0]  add_sum;
   wire [7:0]  sub_diff;

   // Transfer phases: answer one cycle into the access phase.
   assign acc     = psel & penable & ~clearing_q;
   assign done    = acc & pready;
   assign wr_done = done & pwrite;

   // Word n aliases byte 2n+1 high and byte 2n low.
   assign word_ok   = (word_sel_q < `VMS_NAMED_WORDS);
   assign word_lo_a = {2'b00, word_sel_q, 1'b0};
   assign word_hi_a = {2'b00, word_sel_q, 1'b1};

   // Bit k lives in byte k/8 at position k%8.
   assign bit_byte_a = {6'h00, bit_sel_q[4:3]};
   assign bit_byte   = gp_mem[bit_byte_a];

   // Arithmetic operands are only the named bytes, never storage bytes.
   assign op_addr  = pwdata[15:8];
   assign op_ok    = (op_addr < `VMS_NAMED_BYTES);
   assign add_sum  = gp_mem[op_addr] + pwdata[7:0];
   assign sub_diff = gp_mem[op_addr] - pwdata[7:0];

   // Byte pointer for the indirect general file operand; steps only after the access commits.
   ptr_unit #(.W (`VMS_GP_AW)) u_bptr (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .load      (wr_done & (paddr == `VMS_A_BPTR)),
      .load_val  (pwdata[7:0]),
      .step_up   (done & (paddr == `VMS_A_BPTR_INC)),
      .step_down (done & (paddr == `VMS_A_BPTR_DEC)),
      .ptr_q     (bptr)
   );

   // Scratchpad pointer for the indirect scratchpad operand.
   ptr_unit #(.W (`VMS_SP_AW)) u_ptr (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .load      (wr_done & (paddr == `VMS_A_PTR)),
      .load_val  (pwdata[9:0]),
      .step_up   (done & (paddr == `VMS_A_PTR_INC)),
      .step_down (done & (paddr == `VMS_A_PTR_DEC)),
      .ptr_q     (ptr)
   );

   // Selected byte with one bit replaced by the write data.
   always @* begin
      bit_new = bit_byte;
      bit_new[bit_sel_q[2:0]] = pwdata[0];
   end

   // Flags: software write stores, hardware events set and win.
   always @* begin
      flags_d = flags_q;
      if (wr_done && paddr == `VMS_A_FLAGS) begin
         flags_d = pwdata[7:0];
      end
      flags_d[2:0] = flags_d[2:0] | ext_int_evt;
      flags_d[`VMS_FLAG_ANY_EXT] = flags_d[`VMS_FLAG_ANY_EXT] | (|ext_int_evt);
      flags_d[`VMS_FLAG_COMP] = flags_d[`VMS_FLAG_COMP] | comp_change_evt;
      flags_d[`VMS_FLAG_SER] = flags_d[`VMS_FLAG_SER] | serial_rx_evt;
      flags_d[`VMS_FLAG_SLAVE] = flags_d[`VMS_FLAG_SLAVE] | slave_write_evt;
      flags_d[`VMS_FLAG_TMR] = flags_d[`VMS_FLAG_TMR] | timer_ovf_evt;
   end

   // Read data and error answer for the addressed register.
   always @* begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      case (paddr)
         `VMS_A_GP_ADDR: begin
            rd_d = {24'h00_0000, gp_addr_q};
         end
         `VMS_A_GP_DATA: begin
            rd_d = {24'h00_0000, gp_mem[gp_addr_q]};
         end
         `VMS_A_WORD_SEL: begin
            rd_d = {27'h0, word_sel_q};
         end
         `VMS_A_WORD_DATA: begin
            if (word_ok) begin
               rd_d = {16'h0000, gp_mem[word_hi_a], gp_mem[word_lo_a]};
            end
         end
         `VMS_A_BIT_SEL: begin
            rd_d = {27'h0, bit_sel_q};
         end
         `VMS_A_BIT_DATA: begin
            rd_d = {31'h0, bit_byte[bit_sel_q[2:0]]};
         end
         `VMS_A_BPTR: begin
            rd_d = {24'h00_0000, bptr};
         end
         `VMS_A_BPTR_AT, `VMS_A_BPTR_INC, `VMS_A_BPTR_DEC: begin
            rd_d = {24'h00_0000, gp_mem[bptr]};
         end
         `VMS_A_SP_ADDR: begin
            rd_d = {22'h0, sp_addr_q};
         end
         `VMS_A_SP_DATA: begin
            rd_d = {24'h00_0000, sp_mem[sp_addr_q]};
         end
         `VMS_A_PTR: begin
            rd_d = {22'h0, ptr};
         end
         `VMS_A_PTR_AT, `VMS_A_PTR_INC, `VMS_A_PTR_DEC: begin
            rd_d = {24'h00_0000, sp_mem[ptr]};
         end
         `VMS_A_SYS_SEL: begin
            rd_d = {29'h0, sys_sel_q};
         end
         `VMS_A_SYS_DATA: begin
            rd_d = {16'h0000, sys_q[sys_sel_q]};
         end
         `VMS_A_FLAGS: begin
            rd_d = {24'h00_0000, flags_q};
         end
         `VMS_A_PORT: begin
            rd_d = {24'h00_0000, pin_in & `VMS_PORT_MASK};
         end
         `VMS_A_PORT_OUT: begin
            rd_d = {24'h00_0000, port_out_q};
         end
         `VMS_A_DIRS: begin
            rd_d = {24'h00_0000, dir_q};
         end
         `VMS_A_ADD, `VMS_A_SUB: begin
            rd_d = 32'h0000_0000;
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   // Memory writes; after reset a sweep clears both arrays first.
   always @(posedge clk_sys) begin
      if (clearing_q) begin
         sp_mem[clr_cnt_q] <= 8'h00;
         if (clr_cnt_q[9:8] == 2'b00) begin
            gp_mem[clr_cnt_q[7:0]] <= 8'h00;
         end
      end else if (wr_done) begin
         case (paddr)
            `VMS_A_GP_DATA: begin
               gp_mem[gp_addr_q] <= pwdata[7:0];
            end
            `VMS_A_WORD_DATA: begin
               if (word_ok) begin
                  gp_mem[word_lo_a] <= pwdata[7:0];
                  gp_mem[word_hi_a] <= pwdata[15:8];
               end
            end
            `VMS_A_BIT_DATA: begin
               gp_mem[bit_byte_a] <= bit_new;
            end
            `VMS_A_ADD: begin
               if (op_ok) begin
                  gp_mem[op_addr] <= add_sum;
               end
            end
            `VMS_A_SUB: begin
               if (op_ok) begin
                  gp_mem[op_addr] <= sub_diff;
               end
            end
            `VMS_A_BPTR_AT, `VMS_A_BPTR_INC, `VMS_A_BPTR_DEC: begin
               gp_mem[bptr] <= pwdata[7:0];
            end
            `VMS_A_SP_DATA: begin
               sp_mem[sp_addr_q] <= pwdata[7:0];
            end
            `VMS_A_PTR_AT, `VMS_A_PTR_INC, `VMS_A_PTR_DEC: begin
               sp_mem[ptr] <= pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Clearing sweep runs once over the scratchpad depth after reset.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clr_cnt_q  <= 10'h000;
         clearing_q <= 1'b1;
      end else if (clearing_q) begin
         clr_cnt_q <= clr_cnt_q + 10'h001;
         if (clr_cnt_q == `VMS_CLR_LAST) begin
            clearing_q <= 1'b0;
         end
      end
   end

   // System words: hardware strobe wins over a software write.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (i = 0; i < `VMS_SYS_WORDS; i = i + 1) begin
            sys_q[i] <= 16'h0000;
         end
      end else begin
         for (i = 0; i < `VMS_SYS_WORDS; i = i + 1) begin
            if (sys_hw_we[i]) begin
               sys_q[i] <= sys_hw_data;
            end else if (wr_done && paddr == `VMS_A_SYS_DATA && sys_sel_q == i[2:0]) begin
               sys_q[i] <= pwdata[15:0];
            end
         end
      end
   end

   // Selection registers, flags, port and direction bits.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gp_addr_q  <= 8'h00;
         word_sel_q <= 5'h00;
         bit_sel_q  <= 5'h00;
         sp_addr_q  <= 10'h000;
         sys_sel_q  <= 3'h0;
         flags_q    <= 8'h00;
         port_out_q <= 8'h00;
         dir_q      <= 8'h00;
      end else begin
         flags_q <= flags_d;
         if (wr_done) begin
            case (paddr)
               `VMS_A_GP_ADDR: begin
                  gp_addr_q <= pwdata[7:0];
               end
               `VMS_A_WORD_SEL: begin
                  word_sel_q <= pwdata[4:0];
               end
               `VMS_A_BIT_SEL: begin
                  bit_sel_q <= pwdata[4:0];
               end
               `VMS_A_SP_ADDR: begin
                  sp_addr_q <= pwdata[9:0];
               end
               `VMS_A_SYS_SEL: begin
                  sys_sel_q <= pwdata[2:0];
               end
               `VMS_A_PORT, `VMS_A_PORT_OUT: begin
                  port_out_q <= pwdata[7:0] & `VMS_PORT_MASK;
               end
               `VMS_A_DIRS: begin
                  dir_q <= pwdata[7:0] & `VMS_DIR_MASK;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Pin drive: a set direction bit turns its pin into an output.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_out  <= 8'h00;
         pin_oe_n <= 8'hFF;
      end else begin
         pin_out  <= port_out_q & dir_q;
         pin_oe_n <= ~dir_q;
      end
   end

   // APB answer: ready one cycle into the access phase, held off while clearing.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (acc && !pready) begin
         pready  <= 1'b1;
         pslverr <= err_d;
         prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// [hdl/vms_defs.vh]
`ifndef VMS_DEFS_VH
`define VMS_DEFS_VH

// APB register byte addresses.
`define VMS_A_GP_ADDR    8'h00
`define VMS_A_GP_DATA    8'h04
`define VMS_A_WORD_SEL   8'h08
`define VMS_A_WORD_DATA  8'h0C
`define VMS_A_BIT_SEL    8'h10
`define VMS_A_BIT_DATA   8'h14
`define VMS_A_BPTR       8'h18
`define VMS_A_BPTR_AT    8'h1C
`define VMS_A_BPTR_INC   8'h20
`define VMS_A_BPTR_DEC   8'h24
`define VMS_A_SP_ADDR    8'h28
`define VMS_A_SP_DATA    8'h2C
`define VMS_A_PTR        8'h30
`define VMS_A_PTR_AT     8'h34
`define VMS_A_PTR_INC    8'h38
`define VMS_A_PTR_DEC    8'h3C
`define VMS_A_SYS_SEL    8'h40
`define VMS_A_SYS_DATA   8'h44
`define VMS_A_FLAGS      8'h48
`define VMS_A_PORT       8'h4C
`define VMS_A_DIRS       8'h50
`define VMS_A_ADD        8'h54
`define VMS_A_SUB        8'h58
`define VMS_A_PORT_OUT   8'h5C

// Sizes of the variable stores.
`define VMS_NAMED_BYTES  8'h38
`define VMS_NAMED_WORDS  5'h1C
`define VMS_GP_DEPTH     256
`define VMS_SP_DEPTH     1024
`define VMS_SP_AW        10
`define VMS_GP_AW        8
`define VMS_SYS_WORDS    8
`define VMS_CLR_LAST     10'h3FF

// Implemented bit positions of the small port.
`define VMS_PORT_MASK    8'h1E
`define VMS_DIR_MASK     8'h16

// Flag bit positions.
`define VMS_FLAG_ANY_EXT 3
`define VMS_FLAG_COMP    4
`define VMS_FLAG_SER     5
`define VMS_FLAG_SLAVE   6
`define VMS_FLAG_TMR     7

`endif

// [test/core_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Program execution core: issues variable reads and writes as APB master.
module core_model (
   input  wire logic        clk_sys,
   input  wire logic        pready,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [7:0]  paddr,
   output var  logic [31:0] pwdata
);
   // The bus starts idle.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // Optional idle gap, then setup and access held until ready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input int gap);
      repeat (gap) @(posedge clk_sys);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [test/variable_memory_store_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vms_defs.vh"

module variable_memory_store_tb_top;
   logic        clk_sys;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  sys_hw_we;
   logic [15:0] sys_hw_data;
   logic [7:0]  evt;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe_n;
   logic [31:0] r;
   logic [32:0] e;
   logic [32:0] exp_q[$];
   int          failures;
   int          check_count;
   int          cycles;

   variable_memory_store u_variable_memory_store (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sys_hw_we(sys_hw_we), .sys_hw_data(sys_hw_data),
      .ext_int_evt(evt[2:0]), .comp_change_evt(evt[4]), .serial_rx_evt(evt[5]),
      .slave_write_evt(evt[6]), .timer_ovf_evt(evt[7]), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n));

   core_model u_core_model (.clk_sys(clk_sys), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   // Clock and hang limit.
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("MISMATCH %0t run did not finish in time", $time);
         wrap_up();
      end
   end

   // Notes the expected answer of a transfer, then issues it; a write answers with zero data.
   task automatic xfer_note(input logic w, input logic [7:0] a, input logic [31:0] d,
                            input logic [31:0] x);
      exp_q.push_back({a >= 8'h60, x});
      u_core_model.xfer(w, a, d, $urandom_range(2));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer_note(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      xfer_note(1'b0, a, d, d);
   endtask

   // Takes the oldest note whenever the slave answers and compares it.
   always @(posedge clk_sys) begin
      if (pready === 1'b1) begin
         check_count++;
         e = exp_q.pop_front();
         if (prdata !== e[31:0] || pslverr !== e[32]) begin
            failures++;
            $display("MISMATCH %0t addr %h read %h", $time, paddr, prdata);
         end
      end
   end

   task automatic wrap_up();
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      evt = 8'h00;
      sys_hw_we = 8'h00;
      sys_hw_data = 16'h0000;
      pin_in = 8'h00;
      failures = 0;
      check_count = 0;
      cycles = 0;
      r = $urandom(32'h0CCF);
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      wr(`VMS_A_GP_ADDR, 32'hC8);
      rd(`VMS_A_GP_DATA, 32'h0);
      wr(`VMS_A_GP_ADDR, 32'h05);
      wr(`VMS_A_GP_DATA, 32'h02);
      wr(`VMS_A_SUB, 32'h0503);
      rd(`VMS_A_GP_DATA, 32'hFF);
      wr(`VMS_A_ADD, 32'h0503);
      rd(`VMS_A_GP_DATA, 32'h02);
      wr(`VMS_A_GP_ADDR, 32'h38);
      wr(`VMS_A_GP_DATA, 32'h07);
      wr(`VMS_A_ADD, 32'h3801);
      rd(`VMS_A_GP_DATA, 32'h07);
      r = $urandom();
      wr(`VMS_A_WORD_SEL, 32'h1B);
      wr(`VMS_A_WORD_DATA, {16'h0, r[15:0]});
      wr(`VMS_A_GP_ADDR, 32'h37);
      rd(`VMS_A_GP_DATA, {24'h0, r[15:8]});
      wr(`VMS_A_WORD_SEL, 32'h1C);
      rd(`VMS_A_WORD_DATA, 32'h0);
      wr(`VMS_A_GP_ADDR, 32'h01);
      wr(`VMS_A_GP_DATA, 32'h80);
      wr(`VMS_A_BIT_SEL, 32'h0F);
      rd(`VMS_A_BIT_DATA, 32'h1);
      wr(`VMS_A_BIT_SEL, 32'h0E);
      rd(`VMS_A_BIT_DATA, 32'h0);
      wr(`VMS_A_BIT_DATA, 32'h1);
      rd(`VMS_A_GP_DATA, 32'hC0);
      wr(`VMS_A_BPTR, 32'hFF);
      wr(`VMS_A_BPTR_INC, {24'h0, r[7:0]});
      rd(`VMS_A_BPTR, 32'h0);
      wr(`VMS_A_GP_ADDR, 32'hFF);
      rd(`VMS_A_GP_DATA, {24'h0, r[7:0]});
      rd(`VMS_A_BPTR_DEC, 32'h0);
      rd(`VMS_A_BPTR_AT, {24'h0, r[7:0]});
      wr(`VMS_A_SP_ADDR, 32'h3FF);
      wr(`VMS_A_SP_DATA, {24'h0, r[23:16]});
      wr(`VMS_A_PTR, 32'h3FF);
      rd(`VMS_A_PTR_INC, {24'h0, r[23:16]});
      rd(`VMS_A_PTR_DEC, 32'h0);
      rd(`VMS_A_PTR_AT, {24'h0, r[23:16]});
      rd(`VMS_A_PTR, 32'h3FF);
      wr(`VMS_A_SYS_SEL, 32'h2);
      wr(`VMS_A_SYS_DATA, {16'h0, r[31:16]});
      rd(`VMS_A_SYS_DATA, {16'h0, r[31:16]});
      @(posedge clk_sys);
      sys_hw_we <= 8'h04;
      sys_hw_data <= r[15:0];
      @(posedge clk_sys);
      sys_hw_we <= 8'h00;
      rd(`VMS_A_SYS_DATA, {16'h0, r[15:0]});
      for (int i = 0; i < 8; i++) begin
         if (i != 3) begin
            @(posedge clk_sys);
            evt <= 8'h01 << i;
            @(posedge clk_sys);
            evt <= 8'h00;
            rd(`VMS_A_FLAGS, (32'h1 << i) | (i < 3 ? 32'h8 : 32'h0));
            wr(`VMS_A_FLAGS, 32'h0);
         end
      end
      wr(`VMS_A_FLAGS, 32'h5A);
      rd(`VMS_A_FLAGS, 32'h5A);
      @(posedge clk_sys);
      pin_in <= r[31:24];
      rd(`VMS_A_PORT, {24'h0, r[31:24] & 8'h1E});
      wr(`VMS_A_DIRS, 32'hFF);
      rd(`VMS_A_DIRS, 32'h16);
      wr(`VMS_A_PORT, 32'hE7);
      rd(`VMS_A_PORT_OUT, 32'h06);
      wr(`VMS_A_PORT_OUT, 32'hFF);
      repeat (2) @(posedge clk_sys);
      check_count++;
      if (pin_out !== 8'h16 || pin_oe_n !== 8'hE9) begin
         failures++;
         $display("MISMATCH %0t pins %h enables %h", $time, pin_out, pin_oe_n);
      end
      // A second reset in mid-run must wipe flags and stored bytes again.
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`VMS_A_FLAGS, 32'h0);
      wr(`VMS_A_GP_ADDR, 32'h05);
      rd(`VMS_A_GP_DATA, 32'h0);
      rd(8'h60, 32'h0);
      repeat (3) @(posedge clk_sys);
      wrap_up();
   end
endmodule

bind variable_memory_store vms_checker u_vms_checker (.clk_sys(clk_sys), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ext_int_evt(ext_int_evt), .timer_ovf_evt(timer_ovf_evt),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire

// [test/vms_checker.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vms_defs.vh"

// Watches the register bus and the port pins of the variable store.
module vms_checker (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  ext_int_evt,
   input wire logic        timer_ovf_evt,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe_n
);
   logic [10:0] since_rst_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Counts cycles since reset release so the clearing sweep can be checked.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         since_rst_q <= 11'h000;
      end else if (since_rst_q != 11'h7FF) begin
         since_rst_q <= since_rst_q + 11'h001;
      end
   end

   // A completed read of one register.
   sequence s_rd(a);
      pready && !pwrite && paddr == a;
   endsequence

   a_sweep_stall: assert property (pready |-> since_rst_q >= 11'h400)
      else $error("answer given before the clearing sweep ended");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable && $past(penable))
      else $error("ready outside an access phase");
   a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data or error shown outside an answer");
   a_unmapped_err: assert property (pready && paddr >= 8'h60 |-> pslverr && prdata == 32'h0)
      else $error("unmapped address not refused");
   a_port_mask: assert property (s_rd(`VMS_A_PORT) |-> (prdata & ~32'h1E) == 32'h0)
      else $error("port read shows unimplemented bits");
   a_dir_mask: assert property (s_rd(`VMS_A_DIRS) |-> (prdata & ~32'h16) == 32'h0)
      else $error("direction read shows unimplemented bits");
   a_pin_drive: assert property ((pin_oe_n | 8'h16) == 8'hFF &&
      (pin_out & pin_oe_n) == 8'h00)
      else $error("pin driven where no direction bit allows it");
   a_timer_flag: assert property (timer_ovf_evt ##[2:6]
      s_rd(`VMS_A_FLAGS) |-> prdata[7])
      else $error("overflow flag not set after its event");
   a_any_ext_flag: assert property ((|ext_int_evt) ##[2:6]
      s_rd(`VMS_A_FLAGS) |-> prdata[3])
      else $error("summary interrupt flag not set after a pin event");
endmodule
`default_nettype wire
